//--- rtl/wrap_pos_regs.svh
`ifndef WRAP_POS_REGS_SVH
`define WRAP_POS_REGS_SVH

// Width of signed step positions
`define POS_W 32
// Operation select bus width
`define SEL_W 8
// Number of operation data entries
`define ENTRY_N 256
// Wrap range in steps (default one revolution)
`define WRAP_RANGE_DEF 32'h0000_0E10
// Travel limits in steps
`define TRAVEL_MAX 32'h7FFF_FFFF
`define TRAVEL_MIN 32'h8000_0001
// Starting speed and operating speed, steps per profile tick
`define START_SPEED_DEF 16'h0001
`define RUN_SPEED_DEF 16'h0010
// Clock cycles per speed step while ramping
`define RAMP_CYCLES 16'h0004
// Operation type codes
`define OP_ABS 2'h0
`define OP_WRAP_NEAR 2'h1
`define OP_WRAP_FWD 2'h2

`endif

//--- rtl/wrap_pos_pkg.sv
package wrap_pos_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_PLAN = 4'h2,
    ST_MOVE = 4'h4,
    ST_DONE = 4'h8
  } move_state_e;

  typedef struct packed {
    logic [1:0] op_type;
    logic [31:0] position;
  } op_entry_s;

  typedef struct packed {
    logic dir_fwd;
    logic [31:0] distance;
  } move_plan_s;
endpackage

//--- rtl/ramp_profile.sv
`timescale 1ns/10ps
`include "wrap_pos_regs.svh"
// Trapezoid speed profile: start speed, ramp up, hold, ramp down to stop
module ramp_profile
  import wrap_pos_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic go,
  input wire logic [31:0] distance,
  input wire logic [15:0] start_speed,
  input wire logic [15:0] run_speed,
  output logic busy,
  output logic [15:0] speed,
  output logic step_pulse
);
  logic [31:0] remain_reg;
  logic [31:0] decel_dist_reg;
  logic [15:0] ramp_cnt_reg;
  logic [15:0] speed_reg;
  logic [31:0] remain_next;

  always_comb begin
    remain_next = (remain_reg > 32'(speed_reg)) ? remain_reg - 32'(speed_reg) : 32'h0000_0000;
  end

  // Remaining distance and speed stepping
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      remain_reg <= 32'h0000_0000;
      speed_reg <= 16'h0000;
      ramp_cnt_reg <= 16'h0000;
      decel_dist_reg <= 32'h0000_0000;
      busy <= 1'b0;
      step_pulse <= 1'b0;
    end else if (go) begin
      remain_reg <= distance;
      speed_reg <= start_speed;
      ramp_cnt_reg <= 16'h0000;
      decel_dist_reg <= 32'h0000_0000;
      busy <= (distance != 32'h0000_0000);
      step_pulse <= 1'b0;
    end else if (busy) begin
      remain_reg <= remain_next;
      step_pulse <= 1'b1;
      busy <= (remain_next != 32'h0000_0000);
      if (ramp_cnt_reg == `RAMP_CYCLES - 16'h0001) begin
        ramp_cnt_reg <= 16'h0000;
        if (remain_reg <= decel_dist_reg && speed_reg > start_speed) begin
          speed_reg <= speed_reg - 16'h0001;
        end else if (speed_reg < run_speed && remain_reg > 2 * decel_dist_reg) begin
          speed_reg <= speed_reg + 16'h0001;
          decel_dist_reg <= decel_dist_reg + 32'(speed_reg) * 32'(`RAMP_CYCLES);
        end
      end else begin
        ramp_cnt_reg <= ramp_cnt_reg + 16'h0001;
      end
    end else begin
      step_pulse <= 1'b0;
    end
  end

  assign speed = speed_reg;
endmodule

//--- rtl/wrap_positioning_start_handshake.sv
`timescale 1ns/10ps
`include "wrap_pos_regs.svh"
// Notes on behaviour
// - On accepted start, ready drops and the selected entry runs.
// - Ready returns high when the operation is finished.
// - Wrap types read the stored position as a coordinate in the wrap range.
// - Wrap proximity moves in the direction with the shorter distance.
// - Wrap forward always turns forward to the wrapped target.
// - Move starts at start speed, ramps to run speed, holds, ramps down.
// - Absolute-type travel beyond the upper or lower limit raises an operation data alarm; wrap types are not checked.
module wrap_positioning_start_handshake
  import wrap_pos_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [7:0] op_select_inputs,
  input wire logic start,
  input wire logic entry_we,
  input wire logic [7:0] entry_addr,
  input wire op_entry_s entry_wdata,
  input wire logic [31:0] wrap_range,
  output logic ready,
  output logic move_active,
  output logic dir_fwd,
  output logic step_pulse,
  output logic [15:0] speed,
  output logic data_alarm,
  output logic [31:0] command_pos
);
  op_entry_s entry_mem [`ENTRY_N];
  move_state_e state_reg;
  op_entry_s cur_reg;
  move_plan_s plan_reg;
  move_plan_s plan_next;
  logic start_prev_reg;
  logic go_reg;
  logic prof_busy;
  logic prof_step;
  logic [15:0] prof_speed;
  logic [31:0] target_wrapped;
  logic [31:0] cur_wrapped;
  logic [31:0] fwd_dist;
  logic [31:0] rev_dist;
  logic [32:0] abs_travel;
  logic travel_bad;
  logic [31:0] move_remain_reg;
  logic [31:0] step_amt;

  // Operation data table, loaded by configuration port
  always_ff @(posedge clock) begin
    if (entry_we) begin
      entry_mem[entry_addr] <= entry_wdata;
    end
  end

  // Wrap the stored coordinate and present position into range
  always_comb begin
    target_wrapped = $signed(cur_reg.position) % $signed(wrap_range);
    if ($signed(target_wrapped) < 0) begin
      target_wrapped = target_wrapped + wrap_range;
    end
    cur_wrapped = $signed(command_pos) % $signed(wrap_range);
    if ($signed(cur_wrapped) < 0) begin
      cur_wrapped = cur_wrapped + wrap_range;
    end
    fwd_dist = (target_wrapped >= cur_wrapped) ? target_wrapped - cur_wrapped
                                               : target_wrapped + wrap_range - cur_wrapped;
    rev_dist = (fwd_dist == 32'h0000_0000) ? 32'h0000_0000 : wrap_range - fwd_dist;
    abs_travel = {cur_reg.position[31], cur_reg.position} - {command_pos[31], command_pos};
    travel_bad = ($signed(abs_travel) > $signed({1'b0, `TRAVEL_MAX}))
      || ($signed(abs_travel) < $signed({1'b1, `TRAVEL_MIN}));
  end

  // Direction and distance choice by operation type
  always_comb begin
    plan_next.dir_fwd = 1'b1;
    plan_next.distance = 32'h0000_0000;
    case (cur_reg.op_type)
      `OP_WRAP_NEAR: begin
        if (fwd_dist <= rev_dist) begin
          plan_next.dir_fwd = 1'b1;
          plan_next.distance = fwd_dist;
        end else begin
          plan_next.dir_fwd = 1'b0;
          plan_next.distance = rev_dist;
        end
      end
      `OP_WRAP_FWD: begin
        plan_next.dir_fwd = 1'b1;
        plan_next.distance = fwd_dist;
      end
      default: begin
        plan_next.dir_fwd = !abs_travel[32];
        plan_next.distance = abs_travel[32] ? 32'(-abs_travel) : abs_travel[31:0];
      end
    endcase
  end

  // Handshake and move sequencing
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
      ready <= 1'b1;
      move_active <= 1'b0;
      go_reg <= 1'b0;
      start_prev_reg <= 1'b0;
      cur_reg <= '0;
      plan_reg <= '0;
      data_alarm <= 1'b0;
    end else begin
      start_prev_reg <= start;
      go_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          // Rising start while ready; a start held over from last move is ignored
          if (start && !start_prev_reg && ready) begin
            cur_reg <= entry_mem[op_select_inputs];
            ready <= 1'b0;
            data_alarm <= 1'b0;
            state_reg <= ST_PLAN;
          end
        end
        ST_PLAN: begin
          if (cur_reg.op_type == `OP_ABS && travel_bad) begin
            data_alarm <= 1'b1;
            state_reg <= ST_DONE;
          end else begin
            plan_reg <= plan_next;
            go_reg <= 1'b1;
            move_active <= 1'b1;
            state_reg <= ST_MOVE;
          end
        end
        ST_MOVE: begin
          if (!go_reg && !prof_busy) begin
            move_active <= 1'b0;
            state_reg <= ST_DONE;
          end
        end
        ST_DONE: begin
          ready <= 1'b1;
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Last step is clipped so the position lands exactly on the target
  always_comb begin
    step_amt = (move_remain_reg > 32'(prof_speed)) ? 32'(prof_speed) : move_remain_reg;
  end

  // Command position follows each speed step
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      command_pos <= 32'h0000_0000;
      move_remain_reg <= 32'h0000_0000;
      dir_fwd <= 1'b1;
      step_pulse <= 1'b0;
      speed <= 16'h0000;
    end else begin
      // Direction shown from the first cycle of the move
      if (state_reg == ST_PLAN) begin
        dir_fwd <= plan_next.dir_fwd;
        move_remain_reg <= plan_next.distance;
      end else if (prof_busy) begin
        move_remain_reg <= move_remain_reg - step_amt;
      end
      step_pulse <= prof_step;
      speed <= prof_speed;
      if (prof_busy) begin
        if (plan_reg.dir_fwd) begin
          command_pos <= command_pos + step_amt;
        end else begin
          command_pos <= command_pos - step_amt;
        end
      end
    end
  end

  ramp_profile u_profile (
    .clock(clock),
    .arst_n(arst_n),
    .go(go_reg),
    .distance(plan_reg.distance),
    .start_speed(`START_SPEED_DEF),
    .run_speed(`RUN_SPEED_DEF),
    .busy(prof_busy),
    .speed(prof_speed),
    .step_pulse(prof_step)
  );
endmodule

//--- bench/wrap_pos_chk_sva.sv
`timescale 1ns/10ps
// Port-level checks of the start handshake
module wrap_pos_chk (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic start,
  input wire logic ready,
  input wire logic move_active,
  input wire logic dir_fwd,
  input wire logic step_pulse,
  input wire logic data_alarm
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  AST_READY_DROP: assert property (ready && start && !$past(start) |-> ##[1:2] !ready)
    else $error("ready stayed high after a start");
  AST_MOVE_ON: assert property (ready && start && !$past(start) |-> ##[2:3] (move_active || data_alarm))
    else $error("move did not begin");
  AST_READY_BACK: assert property ($fell(move_active) |=> ready)
    else $error("ready late after move end");
  AST_BUSY: assert property (move_active |-> !ready)
    else $error("ready high during move");
  AST_FINISH: assert property ($fell(ready) |-> ##[1:1000] ready)
    else $error("move never finished");
  AST_STEP: assert property (step_pulse |-> !ready)
    else $error("step while ready");
  AST_DIR: assert property (move_active && $past(move_active) |-> $stable(dir_fwd))
    else $error("direction changed in a move");
  AST_ALARM: assert property (data_alarm && !start |=> data_alarm)
    else $error("alarm dropped without start");
endmodule
bind wrap_positioning_start_handshake wrap_pos_chk i_chk (.clock, .arst_n, .start, .ready,
  .move_active, .dir_fwd, .step_pulse, .data_alarm);

//--- bench/host_ctrl_model.sv
`timescale 1ns/10ps
// Host side: select, start, wait for ready
module host_ctrl_model (
  input wire logic clock,
  input wire logic ready,
  output logic [7:0] op_select_inputs,
  output logic start
);
  initial begin
    op_select_inputs = 8'h00;
    start = 1'b0;
  end
  // One request; hold sets how slowly start is released
  task automatic run(input logic [7:0] sel, input int hold);
    @(negedge clock);
    while (!ready) @(negedge clock);
    op_select_inputs = sel;
    @(negedge clock);
    start = 1'b1;
    while (ready) @(negedge clock);
    repeat (hold) @(negedge clock);
    start = 1'b0;
    op_select_inputs = ~sel;
    while (!ready) @(negedge clock);
  endtask
endmodule

//--- bench/wrap_positioning_start_handshake_tb.sv
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin num_errors++; \
  $display("Error %0t got %h exp %h", $time, a, b); end end
module wrap_positioning_start_handshake_tb;
  import wrap_pos_pkg::*;
  logic clock, arst_n, start, entry_we, ready, move_active, dir_fwd, step_pulse, data_alarm;
  logic exp_dir, act_q;
  logic [7:0] sel, entry_addr;
  logic [15:0] speed;
  logic [31:0] command_pos;
  op_entry_s entry_wdata;
  int num_errors, samples_checked, seed, cur, tgt, i, model_pos;
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  wrap_positioning_start_handshake i_dut (.clock, .arst_n, .op_select_inputs(sel), .start,
    .entry_we, .entry_addr, .entry_wdata, .wrap_range(32'h0000_0064), .ready, .move_active,
    .dir_fwd, .step_pulse, .speed, .data_alarm, .command_pos);
  host_ctrl_model i_host (.clock, .ready, .op_select_inputs(sel), .start);
  // Direction on the first cycle of each move
  always @(negedge clock) begin
    if (move_active && !act_q) `CHK(dir_fwd, exp_dir)
    act_q <= move_active;
  end
  // Store one entry, predict direction, run it
  task automatic move(input logic [1:0] op, input int pos, input int hold);
    int forward_only_wrap;
    logic exp_alarm;
    longint trav;
    @(negedge clock);
    entry_addr = 8'($random(seed));
    entry_wdata = '{op, 32'(pos)};
    entry_we = 1'b1;
    @(negedge clock);
    entry_we = 1'b0;
    forward_only_wrap = (pos - cur + 100) % 100;
    trav = longint'(pos) - longint'(model_pos);
    exp_alarm = (op == 2'h0) && ((trav > 64'sd2147483647) || (trav < -64'sd2147483647));
    if (op == 2'h0) begin
      exp_dir = (trav >= 0);
      if (!exp_alarm) model_pos = pos;
    end else if ((op == 2'h2) || (forward_only_wrap <= 100 - forward_only_wrap)) begin
      exp_dir = 1'b1;
      model_pos = model_pos + forward_only_wrap;
    end else begin
      exp_dir = 1'b0;
      model_pos = model_pos - (100 - forward_only_wrap);
    end
    i_host.run(entry_addr, hold);
    `CHK(ready, 1'b1)
    `CHK(command_pos, 32'(model_pos))
    `CHK(data_alarm, exp_alarm)
    cur = ((model_pos % 100) + 100) % 100;
  endtask
  task automatic summarize;
    if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    seed = 32'h51DE;
    arst_n = 1'b0;
    entry_we = 1'b0;
    entry_addr = 8'h00;
    entry_wdata = '0;
    act_q = 1'b0;
    exp_dir = 1'b1;
    cur = 0;
    model_pos = 0;
    num_errors = 0;
    samples_checked = 0;
    repeat (20) @(negedge clock);
    arst_n = 1'b1;
    move(2'h1, 50, 0); // Equal split
    move(2'h2, 10, 3); // Forward the long way
    move(2'h1, 30, 1);
    move(2'h1, 90, 0); // Reverse is shorter
    for (i = 0; i < 12; i++) begin
      tgt = (cur + 1 + ($unsigned($random(seed)) % 99)) % 100;
      move(2'h1 + 2'(i % 2), tgt, i % 3);
    end
    move(2'h0, 20, 1); // Absolute move in range
    move(2'h0, int'(32'h8000_0000), 0); // Travel past lower limit
    summarize;
  end
  // Hang guard
  initial begin
    #2000000;
    num_errors++;
    summarize;
  end
endmodule
